//--- sfb_pkg.sv
// Package for the supply fault status bank: offsets, field layout, reset values.
// Assumes a 32-bit APB slave with word-aligned registers.
package sfb_pkg;
    localparam int SFB_NUM_FAULTS = 8;
    localparam int SFB_REG_W = 16;
    // Register indices; byte address is four times the index
    localparam logic [7:0] SFB_IDX_FLAGS = 8'h0e;
    localparam logic [7:0] SFB_IDX_ENABLE = 8'h20;
    localparam logic [7:0] SFB_IDX_RAW = 8'h21;
    localparam logic [11:0] SFB_ADDR_FLAGS = {2'h0, SFB_IDX_FLAGS, 2'h0};
    localparam logic [11:0] SFB_ADDR_ENABLE = {2'h0, SFB_IDX_ENABLE, 2'h0};
    localparam logic [11:0] SFB_ADDR_RAW = {2'h0, SFB_IDX_RAW, 2'h0};
    // Fault pair index: flag at bit 2*i+1, clear at bit 2*i
    localparam int SFB_P_INPUT_UV = 0;
    localparam int SFB_P_INPUT_OV = 1;
    localparam int SFB_P_CORE_UV = 2;
    localparam int SFB_P_INPUT_OC = 3;
    localparam int SFB_P_PUMP_CAP = 4;
    localparam int SFB_P_PUMP = 5;
    localparam int SFB_P_SYNC = 6;
    localparam int SFB_P_CRC = 7;
    localparam logic [1:0] SFB_EN_WR_ON = 2'h3;
    localparam logic [1:0] SFB_EN_WR_OFF = 2'h1;
    localparam logic [1:0] SFB_EN_RD_ON = 2'h2;
    localparam logic [1:0] SFB_EN_RD_OFF = 2'h0;
    localparam logic [SFB_NUM_FAULTS-1:0] SFB_FLAGS_RST = 8'h00;
    localparam logic [SFB_NUM_FAULTS-1:0] SFB_EN_RST = 8'hff;
endpackage

//--- sfb_supply_fault_status_bank.sv
// Supply fault status bank: eight latched fault flags with paired clear bits,
// per-fault interrupt enables and one level interrupt, behind an APB slave.
// Assumes fault inputs are asynchronous levels from the analog monitors.
`timescale 1ns/1ps
module sfb_supply_fault_status_bank
    import sfb_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [SFB_NUM_FAULTS-1:0] fault_raw,
    output logic irq
);
    logic [SFB_NUM_FAULTS-1:0] sync1_q;
    logic [SFB_NUM_FAULTS-1:0] sync2_q;
    logic [SFB_NUM_FAULTS-1:0] flag_q, flag_d;
    logic [SFB_NUM_FAULTS-1:0] en_q, en_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic irq_q, irq_d;
    logic setup_ph, wr_acc, low_lanes, mapped;

    function automatic logic [SFB_REG_W-1:0] spread(input logic [SFB_NUM_FAULTS-1:0] v,
                                                    input logic odd);
        logic [SFB_REG_W-1:0] r;
        r = '0;
        for (int i = 0; i < SFB_NUM_FAULTS; i++)
        begin
            r[2*i+1] = odd ? v[i] : 1'b0;
            r[2*i] = odd ? 1'b0 : v[i];
        end
        return r;
    endfunction

    function automatic logic [SFB_REG_W-1:0] en_view(input logic [SFB_NUM_FAULTS-1:0] v);
        logic [SFB_REG_W-1:0] r;
        r = '0;
        for (int i = 0; i < SFB_NUM_FAULTS; i++)
        begin
            r[2*i+:2] = v[i] ? SFB_EN_RD_ON : SFB_EN_RD_OFF;
        end
        return r;
    endfunction

    // Fault monitors are outside this clock domain
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= fault_raw;
            sync2_q <= sync1_q;
        end
    end

    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pready_q && pwrite;
    assign low_lanes = pstrb[0] && pstrb[1];
    assign mapped = (paddr == SFB_ADDR_FLAGS) || (paddr == SFB_ADDR_ENABLE) ||
                    (paddr == SFB_ADDR_RAW);

    // Flags and enables
    always_comb
    begin
        flag_d = flag_q;
        en_d = en_q;
        for (int i = 0; i < SFB_NUM_FAULTS; i++)
        begin
            // Clear only when both bits of the pair are one in one write
            if (wr_acc && low_lanes && paddr == SFB_ADDR_FLAGS &&
                pwdata[2*i+1] && pwdata[2*i])
            begin
                flag_d[i] = 1'b0;
            end
            // A fault still present re-sets the flag; set wins over clear
            if (sync2_q[i])
            begin
                flag_d[i] = 1'b1;
            end
            // Values 0 and 2 leave the enable as it is
            if (wr_acc && low_lanes && paddr == SFB_ADDR_ENABLE)
            begin
                if (pwdata[2*i+:2] == SFB_EN_WR_ON)
                begin
                    en_d[i] = 1'b1;
                end
                else if (pwdata[2*i+:2] == SFB_EN_WR_OFF)
                begin
                    en_d[i] = 1'b0;
                end
            end
        end
    end

    // Bus answer: one access cycle, data captured at setup
    always_comb
    begin
        pready_d = setup_ph;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        irq_d = |(flag_d & en_d);
        if (setup_ph)
        begin
            pslverr_d = !mapped || (pwrite && !low_lanes);
            prdata_d = '0;
            if (!pwrite)
            begin
                case (paddr)
                    SFB_ADDR_FLAGS: prdata_d = {16'h0000, spread(flag_q, 1'b1)};
                    SFB_ADDR_ENABLE: prdata_d = {16'h0000, en_view(en_q)};
                    SFB_ADDR_RAW: prdata_d = {16'h0000, spread(sync2_q, 1'b1)};
                    default: prdata_d = '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            flag_q <= SFB_FLAGS_RST;
            en_q <= SFB_EN_RST;
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            flag_q <= flag_d;
            en_q <= en_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            irq_q <= irq_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    logic clr_crc_wr, half_crc_wr;
    assign clr_crc_wr = wr_acc && low_lanes && paddr == SFB_ADDR_FLAGS &&
                        pwdata[2*SFB_P_CRC+1] && pwdata[2*SFB_P_CRC];
    assign half_crc_wr = wr_acc && low_lanes && paddr == SFB_ADDR_FLAGS &&
                         (pwdata[2*SFB_P_CRC+1] != pwdata[2*SFB_P_CRC]);

    a_crc_latch: assert property ($rose(sync2_q[SFB_P_CRC]) |=> flag_q[SFB_P_CRC][*3])
        else $error("crc flag did not latch");
    a_sync_latch: assert property (sync2_q[SFB_P_SYNC] |=> flag_q[SFB_P_SYNC])
        else $error("sync flag did not latch");
    a_pump_flag_rd: assert property (setup_ph && !pwrite && paddr == SFB_ADDR_FLAGS |=>
        prdata[2*SFB_P_PUMP+1] == $past(flag_q[SFB_P_PUMP]))
        else $error("pump flag read wrong");
    a_pair_clear: assert property (clr_crc_wr && !sync2_q[SFB_P_CRC] |=>
        !flag_q[SFB_P_CRC] ##1 !irq || (flag_q & en_q) != 0)
        else $error("pair write did not clear");
    a_half_keeps: assert property (half_crc_wr && !sync2_q[SFB_P_CRC] |=>
        $stable(flag_q[SFB_P_CRC]))
        else $error("half pair write changed flag");
    a_clear_bits_zero: assert property (pready && !$past(pwrite) &&
        $past(paddr) == SFB_ADDR_FLAGS |-> (prdata & 32'h0000_5555) == 32'h0)
        else $error("clear bit read nonzero");
    a_en_on: assert property (wr_acc && low_lanes && paddr == SFB_ADDR_ENABLE &&
        pwdata[1:0] == SFB_EN_WR_ON |=> en_q[0])
        else $error("enable write ignored");
    a_en_off_mask: assert property (wr_acc && low_lanes && paddr == SFB_ADDR_ENABLE &&
        pwdata[15:0] == 16'h5555 |=> ##1 !irq)
        else $error("irq with all disabled");
    a_irq_level: assert property (irq == |(flag_q & en_q))
        else $error("irq not tied to flags");
    a_ready_next: assert property (setup_ph |=> pready ##1 !pready)
        else $error("pready timing wrong");

    c_crc_set: cover property (flag_q[SFB_P_CRC] && irq);
    c_pair_clear: cover property (clr_crc_wr ##1 !flag_q[SFB_P_CRC]);
    c_set_beats_clear: cover property (clr_crc_wr && sync2_q[SFB_P_CRC]);
    c_unmapped: cover property (pready && pslverr);
endmodule // sfb_supply_fault_status_bank

//--- sfb_testbench.sv
// Self-checking bench for the supply fault status bank, driven over APB.
// Assumes the bank answers every access and that flags latch within a few cycles.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module testbench
    import sfb_pkg::*;
;
    logic clk, reset, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata, fl, en_exp;
    logic [3:0] pstrb;
    logic [7:0] fault_raw;
    logic rerr;
    int num_errors = 0;
    int tests_run = 0;

    sfb_supply_fault_status_bank i_sfb_supply_fault_status_bank (.clk(clk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fault_raw(fault_raw), .irq(irq));

    always #10 clk = ~clk;

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50) num_errors++;
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Hold a fault long enough to pass the synchroniser, then let it drain
    task automatic raise(input int i);
        fault_raw <= 8'h01 << i;
        repeat (5) @(posedge clk);
        apb(1'b0, SFB_ADDR_RAW, 32'h0, 4'hf);
        `CHK("raw view", 32'h1 << (2 * i + 1), rdata)
        fault_raw <= 8'h00;
        repeat (4) @(posedge clk);
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("mismatch watchdog expected done seen hang");
        stop_test();
    end

    initial
    begin
        clk = 1'b0; reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hf; fault_raw = 8'h00;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        apb(1'b0, SFB_ADDR_FLAGS, 32'h0, 4'hf);
        `CHK("flags after reset", 32'h0, rdata)
        apb(1'b0, SFB_ADDR_ENABLE, 32'h0, 4'hf);
        `CHK("enables after reset", 32'h0000aaaa, rdata)
        `CHK("irq after reset", 1'b0, irq)
        $display("test reset done");
        for (int i = 0; i < SFB_NUM_FAULTS; i++)
        begin
            fl = 32'h1 << (2 * i + 1);
            raise(i);
            apb(1'b0, SFB_ADDR_FLAGS, 32'h0, 4'hf);
            `CHK("latched flag", fl, rdata)
            `CHK("irq on fault", 1'b1, irq)
            apb(1'b1, SFB_ADDR_FLAGS, fl, 4'hf);
            apb(1'b1, SFB_ADDR_FLAGS, fl >> 1, 4'hf);
            apb(1'b0, SFB_ADDR_FLAGS, 32'h0, 4'hf);
            `CHK("half pair write", fl, rdata)
            `CHK("irq after half write", 1'b1, irq)
            apb(1'b1, SFB_ADDR_FLAGS, fl | (fl >> 1), 4'hf);
            apb(1'b0, SFB_ADDR_FLAGS, 32'h0, 4'hf);
            `CHK("pair clear", 32'h0, rdata)
            `CHK("irq after clear", 1'b0, irq)
        end
        $display("test flags done");
        en_exp = 32'h0000aaaa;
        for (int i = 0; i < SFB_NUM_FAULTS; i++)
        begin
            apb(1'b1, SFB_ADDR_ENABLE, 32'h1 << (2 * i), 4'hf);
            en_exp &= ~(32'h3 << (2 * i));
            apb(1'b0, SFB_ADDR_ENABLE, 32'h0, 4'hf);
            `CHK("enable off", en_exp, rdata)
        end
        raise(SFB_P_PUMP);
        `CHK("irq masked", 1'b0, irq)
        apb(1'b1, SFB_ADDR_ENABLE, 32'h0000aaaa, 4'hf);
        apb(1'b0, SFB_ADDR_ENABLE, 32'h0, 4'hf);
        `CHK("enable write 2h", 32'h0, rdata)
        apb(1'b1, SFB_ADDR_ENABLE, 32'h3 << 10, 4'hf);
        apb(1'b0, SFB_ADDR_ENABLE, 32'h0, 4'hf);
        `CHK("enable on", 32'h00000800, rdata)
        `CHK("irq unmasked", 1'b1, irq)
        apb(1'b1, SFB_ADDR_FLAGS, 32'h00000c00, 4'hf);
        // Irq is registered at the write's access edge; look one edge later
        @(posedge clk);
        `CHK("irq after pump clear", 1'b0, irq)
        apb(1'b1, SFB_ADDR_ENABLE, 32'h0000ffff, 4'hf);
        $display("test enables done");
        raise(SFB_P_INPUT_UV);
        apb(1'b1, SFB_ADDR_FLAGS, 32'h3, 4'hc);
        `CHK("strobe refusal", 1'b1, rerr)
        apb(1'b0, SFB_ADDR_FLAGS, 32'h0, 4'hf);
        `CHK("flag kept", 32'h2, rdata)
        apb(1'b0, 12'hffc, 32'h0, 4'hf);
        `CHK("unmapped error", 1'b1, rerr)
        `CHK("unmapped data", 32'h0, rdata)
        apb(1'b1, SFB_ADDR_FLAGS, 32'h3, 4'hf);
        @(posedge clk);
        `CHK("irq final", 1'b0, irq)
        $display("test errors done");
        stop_test();
    end
endmodule // testbench
